// >>> core/tmr_register_bank.sv
// register bank of a local and remote temperature monitor, link side on its own clock
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_register_bank
  import tmr_pkg::*;
#(
  parameter bit DUAL = 1'b1,
  parameter logic [7:0] MAKER_CODE = `TMR_MAKER_CODE, // arbitrary value
  parameter logic [7:0] PART_CODE = `TMR_PART_CODE // arbitrary value
)(
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // link side, on the serial engine clock
  input wire logic i_link_clk,
  input wire logic i_lk_req,
  input wire logic [1:0] i_lk_kind,
  input wire logic [7:0] i_lk_byte,
  output logic o_lk_ready,
  output logic o_lk_rd_valid,
  output logic [7:0] o_lk_rd_data,
  // converter results and state
  input wire logic i_conv_busy,
  input wire logic i_conv_done,
  input wire logic [1:0] i_conv_chan,
  input wire logic signed [9:0] i_conv_degrees,
  input wire logic [3:0] i_conv_fraction,
  input wire logic i_conv_invalid,
  input wire logic i_conv_open,
  // control towards the converter
  output logic o_oneshot_start,
  output logic o_soft_reset,
  output logic o_shutdown_request,
  output logic o_extended_range,
  output logic o_local_channel_enable,
  output logic o_remote_channel_enable,
  output logic o_second_remote_enable,
  output logic o_series_resistance_cancel,
  output logic [2:0] o_rate_select,
  output logic [7:0] o_gain_correction,
  output logic [7:0] o_ideality_trim_1,
  output logic [7:0] o_ideality_trim_2
);

  localparam logic [7:0] CFG2_RST = DUAL ? `TMR_RST_CHANNEL_ENABLE_DUAL
                                         : `TMR_RST_CHANNEL_ENABLE_SINGLE;
  localparam logic [7:0] CFG2_MASK = DUAL ? `TMR_MASK_CHANNEL_ENABLE_DUAL
                                          : `TMR_MASK_CHANNEL_ENABLE_SINGLE;
  localparam logic [7:0] GAIN_RST = DUAL ? `TMR_RST_GAIN_CORRECTION_DUAL
                                         : `TMR_RST_GAIN_CORRECTION_SINGLE;
  localparam logic [7:0] GAIN_MASK = DUAL ? 8'hFF : `TMR_MASK_GAIN_CORRECTION_SINGLE;

  // high byte from signed integer degrees in either format
  function automatic logic [7:0] encode_high(input logic signed [9:0] deg, input logic ext);
    logic signed [9:0] shifted;
    // degrees far outside the converter's range would wrap here; it never sends them
    shifted = deg + `TMR_EXT_OFFSET;
    if (ext)
    begin
      if (shifted < 10'sd0)
        encode_high = 8'h00;
      else if (shifted > `TMR_EXT_MAX)
        encode_high = 8'hFF;
      else
        encode_high = shifted[7:0];
    end
    else
    begin
      if (deg > `TMR_STD_MAX)
        encode_high = 8'h7F;
      else if (deg < `TMR_STD_MIN)
        encode_high = 8'h80;
      else
        encode_high = deg[7:0];
    end
  endfunction : encode_high

  // is the index a result high byte of a present channel
  function automatic logic is_high(input logic [7:0] idx);
    is_high = (idx == `TMR_IDX_LOCAL_HIGH) || (idx == `TMR_IDX_REMOTE1_HIGH)
              || (DUAL && (idx == `TMR_IDX_REMOTE2_HIGH));
  endfunction : is_high

  // is the index a result low byte of a present channel
  function automatic logic is_low(input logic [7:0] idx);
    is_low = (idx == `TMR_IDX_LOCAL_LOW) || (idx == `TMR_IDX_REMOTE1_LOW)
             || (DUAL && (idx == `TMR_IDX_REMOTE2_LOW));
  endfunction : is_low

  // ---------------- link domain ----------------
  logic lk_req_tgl;
  tmr_req_t lk_kind;
  logic [7:0] lk_byte;
  logic lk_ack_s1;
  logic lk_ack_s2;
  logic lk_ack_s3;
  // core domain signals read by the link side
  logic core_ack_tgl;
  logic [7:0] core_resp;

  // ready returns one link cycle after the answer toggle settles, together with
  // the read valid pulse, so the host never sees ready ahead of its read data
  assign o_lk_ready = (lk_req_tgl == lk_ack_s3);

  // capture a request and hold it until the core answers
  always_ff @(posedge i_link_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lk_req_tgl <= 1'b0;
      lk_kind <= TMR_REQ_INDEX_WRITE;
      lk_byte <= 8'h00;
    end
    else if (i_lk_req && o_lk_ready)
    begin
      lk_req_tgl <= ~lk_req_tgl;
      lk_kind <= tmr_req_t'(i_lk_kind);
      lk_byte <= i_lk_byte;
    end
  end

  // answer toggle brought into the link domain
  always_ff @(posedge i_link_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      lk_ack_s1 <= 1'b0;
      lk_ack_s2 <= 1'b0;
      lk_ack_s3 <= 1'b0;
    end
    else
    begin
      lk_ack_s1 <= core_ack_tgl;
      lk_ack_s2 <= lk_ack_s1;
      lk_ack_s3 <= lk_ack_s2;
    end
  end

  // read data taken once the answer toggle has settled
  always_ff @(posedge i_link_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_lk_rd_valid <= 1'b0;
      o_lk_rd_data <= 8'h00;
    end
    else
    begin
      o_lk_rd_valid <= (lk_ack_s2 != lk_ack_s3) && lk_kind[1];
      if ((lk_ack_s2 != lk_ack_s3) && lk_kind[1])
        o_lk_rd_data <= core_resp;
    end
  end

  // ---------------- core domain ----------------
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic fire;
  logic [7:0] reg_index;
  logic [7:0] cfg1;
  logic [7:0] cfg2;
  logic [7:0] rate;
  logic [7:0] gain;
  logic [7:0] trim1;
  logic [7:0] trim2;
  logic [7:0] res_high [3];
  logic [7:0] res_low [3];
  logic [7:0] shadow_low;
  logic [1:0] shadow_chan;
  logic shadow_valid;
  logic is_wr;
  logic is_rd;
  logic [7:0] next_resp;

  // request toggle brought into the core domain
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      req_s3 <= 1'b0;
    end
    else
    begin
      req_s1 <= lk_req_tgl;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
    end
  end

  // one strike per request; kind and byte stay put until the answer returns
  assign fire = req_s2 ^ req_s3;
  assign is_wr = fire && (lk_kind == TMR_REQ_DATA_WRITE);
  assign is_rd = fire && lk_kind[1];

  // register index, loaded by every index write step
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      reg_index <= `TMR_RST_INDEX;
    else if (fire && (lk_kind == TMR_REQ_INDEX_WRITE))
      reg_index <= lk_byte;
  end

  // writable configuration; read-only and unassigned indices ignore data
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cfg1 <= `TMR_RST_RANGE_SHUTDOWN;
      cfg2 <= CFG2_RST;
      rate <= `TMR_RST_SAMPLE_RATE;
      gain <= GAIN_RST;
      trim1 <= `TMR_RST_IDEALITY_TRIM;
      trim2 <= `TMR_RST_IDEALITY_TRIM;
    end
    else if (is_wr)
    begin
      unique case (reg_index)
        `TMR_IDX_RANGE_SHUTDOWN: cfg1 <= lk_byte & `TMR_MASK_RANGE_SHUTDOWN;
        `TMR_IDX_CHANNEL_ENABLE: cfg2 <= lk_byte & CFG2_MASK;
        `TMR_IDX_SAMPLE_RATE: rate <= lk_byte & `TMR_MASK_SAMPLE_RATE;
        `TMR_IDX_GAIN_CORRECTION: gain <= lk_byte & GAIN_MASK;
        `TMR_IDX_IDEALITY_TRIM_1: trim1 <= lk_byte;
        `TMR_IDX_IDEALITY_TRIM_2: trim2 <= DUAL ? lk_byte : trim2;
        default: cfg1 <= cfg1;
      endcase
    end
  end

  // trigger pulses; a single shot during a conversion is dropped
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_oneshot_start <= 1'b0;
      o_soft_reset <= 1'b0;
    end
    else
    begin
      o_oneshot_start <= is_wr && (reg_index == `TMR_IDX_SINGLE_SHOT) && !i_conv_busy;
      o_soft_reset <= is_wr && (reg_index == `TMR_IDX_SOFT_RESET);
    end
  end

  // result bytes refreshed by the converter only
  // channel code 3, and remote2 on a single-channel part, are dropped
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int i = 0; i < 3; i++)
      begin
        res_high[i] <= `TMR_RST_RESULT;
        res_low[i] <= `TMR_RST_RESULT;
      end
    end
    else if (i_conv_done && ((i_conv_chan != TMR_CH_REMOTE2) || DUAL)
             && (i_conv_chan != 2'b11))
    begin
      res_high[i_conv_chan] <= encode_high(i_conv_degrees,
                                           cfg1[`TMR_BIT_EXTENDED_RANGE]);
      if (i_conv_chan == TMR_CH_LOCAL)
        res_low[i_conv_chan] <= {i_conv_fraction, 2'b00, i_conv_invalid, 1'b0};
      else
        res_low[i_conv_chan] <= {i_conv_fraction, 2'b00, i_conv_invalid, i_conv_open};
    end
  end

  // low byte frozen at each first-read step of a high byte, dropped by any other read
  // a conversion after the freeze leaves the frozen copy alone
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      shadow_low <= 8'h00;
      shadow_chan <= 2'b00;
      shadow_valid <= 1'b0;
    end
    else if (is_rd)
    begin
      if ((lk_kind == TMR_REQ_READ_FIRST) && is_high(reg_index))
      begin
        shadow_low <= res_low[reg_index[1:0]];
        shadow_chan <= reg_index[1:0];
        shadow_valid <= 1'b1;
      end
      else
        shadow_valid <= 1'b0;
    end
  end

  // read value for the current index
  always_comb
  begin
    next_resp = 8'h00;
    if (lk_kind == TMR_REQ_READ_NEXT && is_high(reg_index))
      next_resp = shadow_low;
    else if (is_low(reg_index) && shadow_valid && (shadow_chan == reg_index[1:0]))
      next_resp = shadow_low;
    else if (is_high(reg_index))
      next_resp = res_high[reg_index[1:0]];
    else if (is_low(reg_index))
      next_resp = res_low[reg_index[1:0]];
    else
    begin
      unique case (reg_index)
        `TMR_IDX_CONVERTER_STATE: next_resp = {i_conv_busy, 7'b000_0000};
        `TMR_IDX_RANGE_SHUTDOWN: next_resp = cfg1;
        `TMR_IDX_CHANNEL_ENABLE: next_resp = cfg2;
        `TMR_IDX_SAMPLE_RATE: next_resp = rate;
        `TMR_IDX_GAIN_CORRECTION: next_resp = gain;
        `TMR_IDX_IDEALITY_TRIM_1: next_resp = trim1;
        `TMR_IDX_IDEALITY_TRIM_2: next_resp = DUAL ? trim2 : 8'h00;
        `TMR_IDX_MAKER_CODE: next_resp = MAKER_CODE;
        `TMR_IDX_PART_CODE: next_resp = PART_CODE;
        default: next_resp = 8'h00;
      endcase
    end
  end

  // answer held stable while its toggle crosses to the link
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      core_ack_tgl <= 1'b0;
      core_resp <= 8'h00;
    end
    else if (fire)
    begin
      core_ack_tgl <= ~core_ack_tgl;
      if (lk_kind[1])
        core_resp <= next_resp;
    end
  end

  // control fields to the converter
  assign o_shutdown_request = cfg1[`TMR_BIT_SHUTDOWN_REQUEST];
  assign o_extended_range = cfg1[`TMR_BIT_EXTENDED_RANGE];
  assign o_local_channel_enable = cfg2[`TMR_BIT_LOCAL_CHANNEL_ENABLE];
  assign o_remote_channel_enable = cfg2[`TMR_BIT_REMOTE_CHANNEL_ENABLE];
  assign o_second_remote_enable = cfg2[`TMR_BIT_SECOND_REMOTE_ENABLE];
  assign o_series_resistance_cancel = cfg2[`TMR_BIT_SERIES_RESISTANCE_CANCEL];
  assign o_rate_select = rate[2:0];
  assign o_gain_correction = gain;
  assign o_ideality_trim_1 = trim1;
  assign o_ideality_trim_2 = trim2;

endmodule : tmr_register_bank

// >>> pkg/tmr_consts.svh
// register offsets, field positions, reset values and fixed codes of the temperature register bank
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_IDX_LOCAL_HIGH 8'h00
`define TMR_IDX_REMOTE1_HIGH 8'h01
`define TMR_IDX_REMOTE2_HIGH 8'h02
`define TMR_IDX_CONVERTER_STATE 8'h08
`define TMR_IDX_RANGE_SHUTDOWN 8'h09
`define TMR_IDX_CHANNEL_ENABLE 8'h0A
`define TMR_IDX_SAMPLE_RATE 8'h0B
`define TMR_IDX_GAIN_CORRECTION 8'h0C
`define TMR_IDX_SINGLE_SHOT 8'h0F
`define TMR_IDX_LOCAL_LOW 8'h10
`define TMR_IDX_REMOTE1_LOW 8'h11
`define TMR_IDX_REMOTE2_LOW 8'h12
`define TMR_IDX_IDEALITY_TRIM_1 8'h21
`define TMR_IDX_IDEALITY_TRIM_2 8'h22
`define TMR_IDX_SOFT_RESET 8'hFC
`define TMR_IDX_MAKER_CODE 8'hFE
`define TMR_IDX_PART_CODE 8'hFF
`define TMR_RST_INDEX 8'h00
`define TMR_RST_RESULT 8'h00
`define TMR_RST_RANGE_SHUTDOWN 8'h00
`define TMR_RST_CHANNEL_ENABLE_SINGLE 8'h1C
`define TMR_RST_CHANNEL_ENABLE_DUAL 8'h3C
`define TMR_RST_SAMPLE_RATE 8'h07
`define TMR_RST_GAIN_CORRECTION_SINGLE 8'h08
`define TMR_RST_GAIN_CORRECTION_DUAL 8'h88
`define TMR_RST_IDEALITY_TRIM 8'h00
`define TMR_MASK_RANGE_SHUTDOWN 8'h44
`define TMR_MASK_CHANNEL_ENABLE_SINGLE 8'h1C
`define TMR_MASK_CHANNEL_ENABLE_DUAL 8'h3C
`define TMR_MASK_SAMPLE_RATE 8'h07
`define TMR_MASK_GAIN_CORRECTION_SINGLE 8'h0F
`define TMR_BIT_BUSY 7
`define TMR_BIT_SHUTDOWN_REQUEST 6
`define TMR_BIT_EXTENDED_RANGE 2
`define TMR_BIT_SERIES_RESISTANCE_CANCEL 2
`define TMR_BIT_LOCAL_CHANNEL_ENABLE 3
`define TMR_BIT_REMOTE_CHANNEL_ENABLE 4
`define TMR_BIT_SECOND_REMOTE_ENABLE 5
`define TMR_EXT_OFFSET 10'sd64
`define TMR_STD_MAX 10'sd127
`define TMR_STD_MIN (-10'sd128)
`define TMR_EXT_MAX 10'sd255
`define TMR_MAKER_CODE 8'hA5
`define TMR_PART_CODE 8'h3C
`endif

// >>> pkg/tmr_pkg.sv
// types shared by the temperature register bank
package tmr_pkg;
  // kind of a bus transaction step handed over from the link side
  typedef enum logic [1:0] {
    TMR_REQ_INDEX_WRITE = 2'b00,
    TMR_REQ_DATA_WRITE = 2'b01,
    TMR_REQ_READ_FIRST = 2'b10,
    TMR_REQ_READ_NEXT = 2'b11
  } tmr_req_t;
  // converter channel numbers
  typedef enum logic [1:0] {
    TMR_CH_LOCAL = 2'b00,
    TMR_CH_REMOTE1 = 2'b01,
    TMR_CH_REMOTE2 = 2'b10
  } tmr_chan_t;
endpackage : tmr_pkg

// >>> test/tmr_register_bank_properties.sv
// port timing checks of the temperature register bank
`timescale 1ns/1ps
module tmr_bank_chk (
  // clocks and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_link_clk,
  // link side
  input wire logic i_lk_req,
  input wire logic o_lk_ready,
  input wire logic o_lk_rd_valid,
  input wire logic [7:0] o_lk_rd_data,
  // converter control
  input wire logic o_oneshot_start,
  input wire logic o_soft_reset,
  input wire logic o_extended_range,
  input wire logic [2:0] o_rate_select
);
  // link handshake
  AST_TAKE_BUSY: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    i_lk_req && o_lk_ready |=> !o_lk_ready) else $error("taken request left ready high");
  AST_ANSWER_BOUND: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    $fell(o_lk_ready) |-> ##[1:14] o_lk_ready) else $error("answer too late");
  AST_VALID_READY: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    o_lk_rd_valid |-> o_lk_ready) else $error("read data while busy");
  AST_VALID_PULSE: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    o_lk_rd_valid |=> !o_lk_rd_valid) else $error("read valid too long");
  AST_DATA_HOLD: assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
    !o_lk_rd_valid |-> $stable(o_lk_rd_data)) else $error("read data moved");
  // converter control pulses and levels
  AST_START_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_oneshot_start |=> !o_oneshot_start) else $error("start pulse too long");
  AST_SOFT_PULSE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_soft_reset |=> !o_soft_reset) else $error("soft reset pulse too long");
  AST_ONE_EVENT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !(o_oneshot_start && o_soft_reset)) else $error("two triggers at once");
  AST_CFG_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> !o_extended_range && o_rate_select == 3'h7) else $error("bad reset cfg");
  // main scenarios seen
  COV_READ: cover property (@(posedge i_link_clk) o_lk_rd_valid);
  COV_START: cover property (@(posedge i_clk) o_oneshot_start);
  COV_SOFT: cover property (@(posedge i_clk) o_soft_reset);
endmodule : tmr_bank_chk
bind tmr_register_bank tmr_bank_chk u_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_link_clk(i_link_clk), .i_lk_req(i_lk_req),
  .o_lk_ready(o_lk_ready), .o_lk_rd_valid(o_lk_rd_valid), .o_lk_rd_data(o_lk_rd_data),
  .o_oneshot_start(o_oneshot_start), .o_soft_reset(o_soft_reset),
  .o_extended_range(o_extended_range), .o_rate_select(o_rate_select)
);

// >>> test/tmr_host_model.sv
// host controller model driving the link side of the register bank
`timescale 1ns/1ps
module tmr_host_model (
  // link clock and answers
  input wire logic i_link_clk,
  input wire logic i_ready,
  input wire logic [7:0] i_rd_data,
  // requests
  output logic o_req = 1'b0,
  output logic [1:0] o_kind = 2'b00,
  output logic [7:0] o_byte = 8'h00
);
  // one step: wait, hold request until taken, then wait for ready bounded
  task automatic xfer(input logic [1:0] k, input logic [7:0] b, input int gap,
                      output logic [7:0] d, output logic to);
    int n;
    to = 1'b1;
    d = 8'h00;
    repeat (gap + 1) @(posedge i_link_clk);
    o_req <= 1'b1;
    o_kind <= k;
    o_byte <= b;
    n = 0;
    do
    begin
      @(posedge i_link_clk);
      n++;
    end while (!i_ready && n < 40);
    o_req <= 1'b0;
    o_byte <= ~b; // released byte line does not keep its value
    for (n = 0; n < 40; n++)
    begin
      @(posedge i_link_clk);
      if (i_ready)
      begin
        d = i_rd_data;
        to = 1'b0;
        break;
      end
    end
  endtask : xfer
endmodule : tmr_host_model

// >>> test/tmr_register_bank_tb.sv
// self-checking bench of the temperature register bank
`timescale 1ns/1ps
`include "tmr_consts.svh"
module tmr_register_bank_tb;
  // clocks, reset and converter stimulus
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_b = 1'b0;
  logic busy = 1'b0;
  logic done = 1'b0;
  logic [1:0] chan = 2'b00;
  logic signed [9:0] deg = 10'h000;
  logic [3:0] frac = 4'h0;
  logic inv = 1'b0;
  logic opn = 1'b0;
  // link and control outputs
  logic req, rdy, rdv, os, sr, ext, shut, en_loc, en_rem, en_rem2, res_cancel;
  logic [1:0] kind;
  logic [2:0] rate;
  logic [7:0] lbyte, rdat, got;
  logic [7:0] gc, nt1, nt2;
  logic [7:0] n_os = 8'h00;
  logic [7:0] n_sr = 8'h00;
  logic [7:0] n_rv = 8'h00;
  int err_count = 0;
  int tests_run = 0;
  int gp = 0;
  localparam logic [7:0] RIX [11] = '{8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h21, 8'h22,
    8'hFE, 8'hFF, 8'h05, 8'h01, 8'h12};
  localparam logic [7:0] REX [11] = '{8'h00, 8'h3C, 8'h07, 8'h88, 8'h00, 8'h00,
    `TMR_MAKER_CODE, `TMR_PART_CODE, 8'h00, 8'h00, 8'h00};
  // clock makers, link clock unrelated in phase
  initial forever #5 clk = ~clk;
  initial
  begin
    #3;
    forever #6 lclk = ~lclk;
  end
  // count trigger pulses
  always @(posedge clk)
  begin
    n_os <= n_os + {7'h00, os};
    n_sr <= n_sr + {7'h00, sr};
  end
  // count read valid pulses on the link side
  always @(posedge lclk)
    n_rv <= n_rv + {7'h00, rdv};
  tmr_register_bank DUT (
    .i_clk(clk), .i_rst_b(rst_b), .i_link_clk(lclk), .i_lk_req(req), .i_lk_kind(kind),
    .i_lk_byte(lbyte), .o_lk_ready(rdy), .o_lk_rd_valid(rdv), .o_lk_rd_data(rdat),
    .i_conv_busy(busy), .i_conv_done(done), .i_conv_chan(chan), .i_conv_degrees(deg),
    .i_conv_fraction(frac), .i_conv_invalid(inv), .i_conv_open(opn),
    .o_oneshot_start(os), .o_soft_reset(sr), .o_shutdown_request(shut),
    .o_extended_range(ext), .o_local_channel_enable(en_loc), .o_remote_channel_enable(en_rem),
    .o_second_remote_enable(en_rem2), .o_series_resistance_cancel(res_cancel),
    .o_rate_select(rate), .o_gain_correction(gc), .o_ideality_trim_1(nt1),
    .o_ideality_trim_2(nt2)
  );
  tmr_host_model host (
    .i_link_clk(lclk), .i_ready(rdy), .i_rd_data(rdat), .o_req(req), .o_kind(kind),
    .o_byte(lbyte)
  );
  // verdict and end of run
  task finish_test();
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  // byte comparison
  task chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one link step, a hang ends the run
  task x(input logic [1:0] k, input logic [7:0] b);
    logic to;
    host.xfer(k, b, gp, got, to);
    if (to)
    begin
      err_count++;
      finish_test();
    end
  endtask : x
  task wr(input logic [7:0] a, input logic [7:0] v);
    x(2'd0, a);
    x(2'd1, v);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    x(2'd0, a);
    x(2'd2, 8'h00);
    chk(got, e);
  endtask : rd
  // one finished conversion on a channel
  task conv(input logic [1:0] c, input logic signed [9:0] d, input logic [3:0] f,
            input logic iv, input logic op);
    @(posedge clk);
    done <= 1'b1;
    chan <= c;
    deg <= d;
    frac <= f;
    inv <= iv;
    opn <= op;
    @(posedge clk);
    done <= 1'b0;
  endtask : conv
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    conv(2'd0, 10'sd25, 4'h0, 1'b0, 1'b0);
    x(2'd2, 8'h00);
    chk(got, 8'h19);
    chk({4'h0, en_rem2, en_rem, en_loc, res_cancel}, 8'h0F);
    chk(gc, 8'h88);
    chk(nt1 | nt2, 8'h00);
    for (int i = 0; i < 11; i++)
      rd(RIX[i], REX[i]);
    busy <= 1'b1;
    rd(8'h08, 8'h80);
    wr(8'h0F, 8'h5A);
    chk(n_os, 8'h00);
    busy <= 1'b0;
    gp = 3;
    wr(8'h0F, 8'h00);
    chk(n_os, 8'h01);
    wr(8'hFC, 8'h33);
    chk(n_sr, 8'h01);
    gp = 0;
    conv(2'd0, -10'sd20, 4'h5, 1'b1, 1'b1);
    conv(2'd1, 10'sd20, 4'hF, 1'b0, 1'b1);
    conv(2'd2, 10'sd200, 4'h8, 1'b1, 1'b0);
    rd(8'h00, 8'hEC);
    rd(8'h10, 8'h52);
    rd(8'h11, 8'hF1);
    rd(8'h02, 8'h7F);
    rd(8'h12, 8'h82);
    rd(8'h00, 8'hEC);
    conv(2'd0, -10'sd20, 4'h9, 1'b0, 1'b0);
    rd(8'h10, 8'h52);
    rd(8'h00, 8'hEC);
    conv(2'd0, -10'sd20, 4'h3, 1'b0, 1'b0);
    rd(8'h08, 8'h00);
    rd(8'h10, 8'h30);
    rd(8'h01, 8'h14);
    conv(2'd1, 10'sd21, 4'h2, 1'b1, 1'b0);
    x(2'd3, 8'h00);
    chk(got, 8'hF1);
    rd(8'h01, 8'h15);
    wr(8'h09, 8'hFF);
    rd(8'h09, 8'h44);
    chk({7'h00, ext}, 8'h01);
    chk({7'h00, shut}, 8'h01);
    conv(2'd0, -10'sd64, 4'h0, 1'b0, 1'b0);
    conv(2'd1, 10'sd150, 4'h4, 1'b0, 1'b0);
    rd(8'h00, 8'h00);
    rd(8'h01, 8'hD6);
    wr(8'h01, 8'hAA);
    rd(8'h01, 8'hD6);
    wr(8'hFE, 8'h00);
    rd(8'hFE, `TMR_MAKER_CODE);
    wr(8'h0B, 8'hFA);
    chk({5'h00, rate}, 8'h02);
    wr(8'h0A, 8'h00);
    chk({4'h0, en_rem2, en_rem, en_loc, res_cancel}, 8'h00);
    wr(8'h0C, 8'h5A);
    chk(gc, 8'h5A);
    wr(8'h21, 8'h3C);
    wr(8'h22, 8'hC3);
    chk(nt1, 8'h3C);
    chk(nt2, 8'hC3);
    wr(8'h30, 8'h77);
    rd(8'h0B, 8'h02);
    repeat (2) @(posedge lclk);
    chk(n_rv, 8'h20);
    finish_test();
  end
endmodule : tmr_register_bank_tb
